/* core/iopc_pkg.sv */
package iopc_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NPINS_DEF = 8;
   localparam int FUNC_W = 3;
   localparam int NFUNC = 8;
   localparam int DRV_W = 3;
   localparam int ADDR_W = 8;
   // Pins able to feed the ADC; value is a plain default
   localparam logic [7:0] ANALOG_MASK_DEF = 8'hf0;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] A_OUTEN = 8'h00;
   localparam logic [7:0] A_ODRAIN = 8'h04;
   localparam logic [7:0] A_PULLUP = 8'h08;
   localparam logic [7:0] A_PULLDN = 8'h0c;
   localparam logic [7:0] A_DEBEN = 8'h10;
   localparam logic [7:0] A_IRQEN = 8'h14;
   localparam logic [7:0] A_IRQEDGE = 8'h18;
   localparam logic [7:0] A_IRQRISE = 8'h1c;
   localparam logic [7:0] A_IRQFALL = 8'h20;
   localparam logic [7:0] A_IRQFLAG = 8'h24;
   localparam logic [7:0] A_DOUT = 8'h28;
   localparam logic [7:0] A_DIN = 8'h2c;
   localparam logic [7:0] A_ANALOG = 8'h30;
   localparam logic [7:0] A_DRIVE = 8'h34;
   localparam logic [7:0] A_FUNC = 8'h38;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_CFG = 32'h0000_0000;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int DEB_TIME_NS = 1000;
   localparam int DEB_CYCLES_RAW = (DEB_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int DEB_CYCLES = (DEB_CYCLES_RAW < 1) ? 1 : DEB_CYCLES_RAW;
endpackage

/* core/iopc_pin_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_pin_filter
#(
   parameter int DEB_CNT = iopc_pkg::DEB_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_raw,
   input wire logic deb_en,
   output logic level
);
   import iopc_pkg::*;
   localparam int CNT_W = $clog2(DEB_CNT + 1);

   logic sync1_ff, sync2_ff, stable_ff;
   logic nxt_sync1, nxt_sync2, nxt_stable;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;

   // Two-stage synchroniser, then an optional hold-off filter
   always_comb
   begin
      nxt_sync1 = pin_raw;
      nxt_sync2 = sync1_ff;
      nxt_stable = stable_ff;
      nxt_cnt = '0;
      if (!deb_en)
      begin
         nxt_stable = sync2_ff;
      end
      else if (sync2_ff != stable_ff)
      begin
         // A glitch shorter than the hold-off restarts the count
         if (cnt_ff == CNT_W'(DEB_CNT - 1))
         begin
            nxt_stable = sync2_ff;
         end
         else
         begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         stable_ff <= 1'b0;
         cnt_ff <= '0;
      end
      else
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         stable_ff <= nxt_stable;
         cnt_ff <= nxt_cnt;
      end
   end

   assign level = stable_ff;
endmodule
`default_nettype wire

/* core/iopc_pin_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_pin_irq
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   input wire logic edge_mode,
   input wire logic rise_sel,
   input wire logic fall_sel,
   input wire logic flag_clr,
   output logic flag
);
   logic prev_ff, flag_ff;
   logic nxt_prev, nxt_flag, hit;

   // Edge mode looks at transitions, level mode at the level itself
   always_comb
   begin
      nxt_prev = level;
      if (edge_mode)
      begin
         hit = (rise_sel & level & ~prev_ff) | (fall_sel & ~level & prev_ff);
      end
      else
      begin
         hit = (rise_sel & level) | (fall_sel & ~level);
      end
      // A new event in the clearing cycle keeps the flag set
      nxt_flag = hit | (flag_ff & ~flag_clr);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_ff <= 1'b0;
         flag_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= nxt_prev;
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;
endmodule
`default_nettype wire

/* core/iopc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_top
#(
   parameter int NPINS = iopc_pkg::NPINS_DEF,
   parameter logic [NPINS-1:0] ANALOG_MASK = iopc_pkg::ANALOG_MASK_DEF,
   parameter int DEB_CNT = iopc_pkg::DEB_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [iopc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NPINS-1:0] pin_i,
   output logic [NPINS-1:0] pin_o,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] pin_pu_en,
   output logic [NPINS-1:0] pin_pd_en,
   output logic [NPINS*iopc_pkg::DRV_W-1:0] pin_drive,
   output logic [NPINS-1:0] pin_analog_en,
   input wire logic [NPINS*iopc_pkg::NFUNC-1:0] periph_o,
   input wire logic [NPINS*iopc_pkg::NFUNC-1:0] periph_oe,
   output logic [NPINS*iopc_pkg::NFUNC-1:0] periph_i,
   output logic irq,
   output logic wake_request
);
   import iopc_pkg::*;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [NPINS-1:0] outen_ff, odrain_ff, pullup_ff, pulldn_ff;
   logic [NPINS-1:0] deben_ff, irqen_ff, irqedge_ff, irqrise_ff;
   logic [NPINS-1:0] irqfall_ff, dout_ff, analog_ff;
   logic [NPINS*DRV_W-1:0] drive_ff;
   logic [NPINS*FUNC_W-1:0] func_ff;
   logic [NPINS-1:0] nxt_outen, nxt_odrain, nxt_pullup, nxt_pulldn;
   logic [NPINS-1:0] nxt_deben, nxt_irqen, nxt_irqedge, nxt_irqrise;
   logic [NPINS-1:0] nxt_irqfall, nxt_dout, nxt_analog;
   logic [NPINS*DRV_W-1:0] nxt_drive;
   logic [NPINS*FUNC_W-1:0] nxt_func;

   // Pin side state
   logic [NPINS-1:0] level, flag, flag_clr;
   logic [NPINS-1:0] pin_o_ff, pin_oe_ff, pu_ff, pd_ff, ana_ff;
   logic [NPINS-1:0] nxt_pin_o, nxt_pin_oe, nxt_pu, nxt_pd, nxt_ana;
   logic [NPINS*NFUNC-1:0] periph_i_ff, nxt_periph_i;
   logic irq_ff, nxt_irq;

   // Bus decode
   logic wr_en, rd_hit;
   logic [NPINS-1:0] wdat;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign wdat = pwdata[NPINS-1:0];

   // Address decode and read mux; unmapped offsets answer with an error
   always_comb
   begin
      rd_hit = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         A_OUTEN: prdata = 32'(outen_ff);
         A_ODRAIN: prdata = 32'(odrain_ff);
         A_PULLUP: prdata = 32'(pullup_ff);
         A_PULLDN: prdata = 32'(pulldn_ff);
         A_DEBEN: prdata = 32'(deben_ff);
         A_IRQEN: prdata = 32'(irqen_ff);
         A_IRQEDGE: prdata = 32'(irqedge_ff);
         A_IRQRISE: prdata = 32'(irqrise_ff);
         A_IRQFALL: prdata = 32'(irqfall_ff);
         A_IRQFLAG: prdata = 32'(flag);
         A_DOUT: prdata = 32'(dout_ff);
         A_DIN: prdata = 32'(level);
         A_ANALOG: prdata = 32'(analog_ff);
         A_DRIVE: prdata = 32'(drive_ff);
         A_FUNC: prdata = 32'(func_ff);
         default: rd_hit = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~rd_hit;

   // Writing one to a flag bit clears it; zeros leave it alone
   assign flag_clr = (wr_en && paddr == A_IRQFLAG) ? wdat : '0;

   // ---------------------------------------------------------------
   // Register write path
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_outen = outen_ff;
      nxt_odrain = odrain_ff;
      nxt_pullup = pullup_ff;
      nxt_pulldn = pulldn_ff;
      nxt_deben = deben_ff;
      nxt_irqen = irqen_ff;
      nxt_irqedge = irqedge_ff;
      nxt_irqrise = irqrise_ff;
      nxt_irqfall = irqfall_ff;
      nxt_dout = dout_ff;
      nxt_analog = analog_ff;
      nxt_drive = drive_ff;
      nxt_func = func_ff;
      if (wr_en)
      begin
         case (paddr)
            A_OUTEN: nxt_outen = wdat;
            A_ODRAIN: nxt_odrain = wdat;
            A_PULLUP: nxt_pullup = wdat;
            A_PULLDN: nxt_pulldn = wdat;
            A_DEBEN: nxt_deben = wdat;
            A_IRQEN: nxt_irqen = wdat;
            A_IRQEDGE: nxt_irqedge = wdat;
            A_IRQRISE: nxt_irqrise = wdat;
            A_IRQFALL: nxt_irqfall = wdat;
            A_DOUT: nxt_dout = wdat;
            // Bits of pins without an analog path stay zero
            A_ANALOG: nxt_analog = wdat & ANALOG_MASK;
            A_DRIVE: nxt_drive = pwdata[NPINS*DRV_W-1:0];
            A_FUNC: nxt_func = pwdata[NPINS*FUNC_W-1:0];
            default: nxt_outen = outen_ff;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         outen_ff <= RST_CFG[NPINS-1:0];
         odrain_ff <= RST_CFG[NPINS-1:0];
         pullup_ff <= RST_CFG[NPINS-1:0];
         pulldn_ff <= RST_CFG[NPINS-1:0];
         deben_ff <= RST_CFG[NPINS-1:0];
         irqen_ff <= RST_CFG[NPINS-1:0];
         irqedge_ff <= RST_CFG[NPINS-1:0];
         irqrise_ff <= RST_CFG[NPINS-1:0];
         irqfall_ff <= RST_CFG[NPINS-1:0];
         dout_ff <= RST_CFG[NPINS-1:0];
         analog_ff <= RST_CFG[NPINS-1:0];
         drive_ff <= RST_CFG[NPINS*DRV_W-1:0];
         func_ff <= RST_CFG[NPINS*FUNC_W-1:0];
      end
      else
      begin
         outen_ff <= nxt_outen;
         odrain_ff <= nxt_odrain;
         pullup_ff <= nxt_pullup;
         pulldn_ff <= nxt_pulldn;
         deben_ff <= nxt_deben;
         irqen_ff <= nxt_irqen;
         irqedge_ff <= nxt_irqedge;
         irqrise_ff <= nxt_irqrise;
         irqfall_ff <= nxt_irqfall;
         dout_ff <= nxt_dout;
         analog_ff <= nxt_analog;
         drive_ff <= nxt_drive;
         func_ff <= nxt_func;
      end
   end

   // ---------------------------------------------------------------
   // Per-pin input filter and interrupt detect
   // ---------------------------------------------------------------
   // Analog pins still pass through the filter; software ignores DIN there
   for (genvar g = 0; g < NPINS; g++)
   begin : g_pin
      iopc_pin_filter #(.DEB_CNT(DEB_CNT)) u_filt
      (
         .pclk(pclk),
         .presetn(presetn),
         .pin_raw(pin_i[g]),
         .deb_en(deben_ff[g]),
         .level(level[g])
      );

      iopc_pin_irq u_irq
      (
         .pclk(pclk),
         .presetn(presetn),
         .level(level[g]),
         .edge_mode(irqedge_ff[g]),
         .rise_sel(irqrise_ff[g]),
         .fall_sel(irqfall_ff[g]),
         .flag_clr(flag_clr[g]),
         .flag(flag[g])
      );
   end

   // ---------------------------------------------------------------
   // Pin drive and function routing
   // ---------------------------------------------------------------
   // Function 0 is software GPIO, 1..7 belong to on-chip peripherals
   always_comb
   begin
      logic d, e;
      int unsigned f;
      d = 1'b0;
      e = 1'b0;
      f = 0;
      nxt_periph_i = '0;
      for (int i = 0; i < NPINS; i++)
      begin
         f = int'(func_ff[i*FUNC_W +: FUNC_W]);
         if (f == 0)
         begin
            d = dout_ff[i];
            e = outen_ff[i];
         end
         else
         begin
            d = periph_o[i*NFUNC + f];
            e = periph_oe[i*NFUNC + f];
         end
         // Open drain only ever pulls low; a high is left to the pull-up
         if (odrain_ff[i])
         begin
            nxt_pin_oe[i] = e & ~d;
            nxt_pin_o[i] = 1'b0;
         end
         else
         begin
            nxt_pin_oe[i] = e;
            nxt_pin_o[i] = d;
         end
         // Analog mode cuts the pin off from the drive and input of functions 0..7; DIN and the pin interrupt still see it
         if (analog_ff[i])
         begin
            nxt_pin_oe[i] = 1'b0;
            nxt_pin_o[i] = 1'b0;
         end
         else
         begin
            nxt_periph_i[i*NFUNC + f] = level[i];
         end
         nxt_ana[i] = analog_ff[i];
         // Both pulls on together is software's error; passed as set
         nxt_pu[i] = pullup_ff[i] & ~analog_ff[i];
         nxt_pd[i] = pulldn_ff[i] & ~analog_ff[i];
      end
   end

   // Interrupt and wake need both flag and enable
   assign nxt_irq = |(flag & irqen_ff);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_o_ff <= '0;
         pin_oe_ff <= '0;
         pu_ff <= '0;
         pd_ff <= '0;
         ana_ff <= '0;
         periph_i_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         pin_o_ff <= nxt_pin_o;
         pin_oe_ff <= nxt_pin_oe;
         pu_ff <= nxt_pu;
         pd_ff <= nxt_pd;
         ana_ff <= nxt_ana;
         periph_i_ff <= nxt_periph_i;
         irq_ff <= nxt_irq;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign pin_o = pin_o_ff;
   assign pin_oe = pin_oe_ff;
   assign pin_pu_en = pu_ff;
   assign pin_pd_en = pd_ff;
   assign pin_analog_en = ana_ff;
   assign pin_drive = drive_ff;
   assign periph_i = periph_i_ff;
   assign irq = irq_ff;
   // Same term feeds the wake unit so a pin can end deep sleep
   assign wake_request = irq_ff;
endmodule
`default_nettype wire

/* sim/iopc_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Pad ring: own driver wins, then the board, then the weak pulls
module iopc_pad_model
#(
   parameter int NPINS = 8
)
(
   input wire logic pclk,
   input wire logic [NPINS-1:0] pin_o,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pu_en,
   input wire logic [NPINS-1:0] pin_pd_en,
   input wire logic [NPINS-1:0] ext_en,
   input wire logic [NPINS-1:0] ext_val,
   output logic [NPINS-1:0] pin_i
);
   // A floating pad toggles so that no stale level passes for a driven one
   logic [NPINS-1:0] float_ff = '0;
   always @(posedge pclk)
      float_ff <= ~float_ff;
   // Level resolution per pin
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
         pin_i[i] = pin_oe[i] ? pin_o[i] : ext_en[i] ? ext_val[i] :
            pin_pu_en[i] ? 1'b1 : pin_pd_en[i] ? 1'b0 : float_ff[i];
   end
endmodule
`default_nettype wire

/* sim/iopc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_properties
import iopc_pkg::*;
#(
   parameter int NPINS = 8,
   parameter logic [NPINS-1:0] ANALOG_MASK = 8'hf0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [iopc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NPINS-1:0] pin_i,
   input wire logic [NPINS-1:0] pin_o,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pu_en,
   input wire logic [NPINS-1:0] pin_pd_en,
   input wire logic [NPINS*iopc_pkg::DRV_W-1:0] pin_drive,
   input wire logic [NPINS-1:0] pin_analog_en,
   input wire logic [NPINS*iopc_pkg::NFUNC-1:0] periph_o,
   input wire logic [NPINS*iopc_pkg::NFUNC-1:0] periph_oe,
   input wire logic [NPINS*iopc_pkg::NFUNC-1:0] periph_i,
   input wire logic irq,
   input wire logic wake_request
);
   // ----
   // Helpers
   // ----
   logic acc, wr_acc, mapped, leak;
   logic [NPINS-1:0] wbits;
   assign acc = psel & penable;
   assign wr_acc = acc & pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= A_FUNC);
   assign wbits = pwdata[NPINS-1:0];
   // Any analog pin still feeding a function input
   always_comb
   begin
      leak = 1'b0;
      for (int i = 0; i < NPINS; i++)
         leak = leak | (pin_analog_en[i] & (|periph_i[i*NFUNC +: NFUNC]));
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----
   // Properties
   // ----
   ready_high_a: assert property (pready)
      else $error("pready low");
   bad_addr_a: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr wrong");
   bad_read_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   wake_follow_a: assert property (wake_request == irq)
      else $error("wake differs from irq");
   analog_pull_a: assert property (((pin_pu_en | pin_pd_en) & pin_analog_en) == '0)
      else $error("pull on analog pin");
   analog_pins_a: assert property ((pin_analog_en & ~ANALOG_MASK) == '0)
      else $error("analog on incapable pin");
   analog_mux_a: assert property (!leak)
      else $error("analog pin reaches function");
   irq_mask_a: assert property (wr_acc && paddr == A_IRQEN && wbits == '0
      |=> ##1 !irq)
      else $error("irq while disabled");
   drive_hold_a: assert property (!(wr_acc && paddr == A_DRIVE)
      |=> $stable(pin_drive))
      else $error("drive moved without write");
   pull_write_a: assert property (wr_acc && paddr == A_PULLUP
      |=> ##1 pin_pu_en == ($past(wbits, 2) & ~pin_analog_en))
      else $error("pull-up not as written");
endmodule
bind iopc_top iopc_properties #(.NPINS(NPINS), .ANALOG_MASK(ANALOG_MASK)) u_props (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
   .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .pin_drive(pin_drive),
   .pin_analog_en(pin_analog_en), .periph_o(periph_o), .periph_oe(periph_oe),
   .periph_i(periph_i), .irq(irq), .wake_request(wake_request));
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("mismatch %s expected %h seen %h", nm, e, g); \
      end \
   end
module testbench;
   import iopc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
   logic [31:0] pwdata = 32'h0, rdata, prdata, msk;
   logic [63:0] periph_o = 64'h965ac33ca5690ff0, periph_oe = '1, periph_i, exp64;
   logic pready, pslverr, rerr, irq, wake;
   logic [7:0] pin_i, pin_o, pin_oe, pu, pd, ana, exp8;
   logic [23:0] drive;
   int n_mismatch = 0, tests_run = 0, cycles = 0;
   logic [7:0] ra [13] = '{A_OUTEN, A_ODRAIN, A_PULLUP, A_PULLDN, A_DEBEN, A_IRQEN,
      A_IRQEDGE, A_IRQRISE, A_IRQFALL, A_DOUT, A_ANALOG, A_DRIVE, A_FUNC};
   // Mode, rise, fall, start level, end level, expected flag
   logic [5:0] cases [9] = '{6'b110011, 6'b110100, 6'b101010, 6'b101101, 6'b111011,
      6'b111101, 6'b010011, 6'b001101, 6'b010000};

   iopc_top #(.DEB_CNT(4)) DUT (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu_en(pu),
      .pin_pd_en(pd), .pin_drive(drive), .pin_analog_en(ana), .periph_o(periph_o),
      .periph_oe(periph_oe), .periph_i(periph_i), .irq(irq), .wake_request(wake));
   iopc_pad_model #(.NPINS(8)) u_pads (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_pu_en(pu), .pin_pd_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

   always #2 pclk = ~pclk;
   // Cut a hang short
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; the slave may stretch the access phase
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rdata)
   endtask
   // Configure pin 0, clear flags, then move the pin
   task automatic irq_case(input logic [5:0] c);
      ext_val[0] <= c[2];
      wr(A_IRQEDGE, {31'h0, c[5]});
      wr(A_IRQRISE, {31'h0, c[4]});
      wr(A_IRQFALL, {31'h0, c[3]});
      wr(A_IRQFLAG, 32'hff);
      ext_val[0] <= c[1];
      cyc(6);
      rd(A_IRQFLAG, {31'h0, c[0]});
   endtask
   task automatic pulse(input int n);
      ext_val[0] <= 1'b1;
      cyc(n);
      ext_val[0] <= 1'b0;
      cyc(12);
   endtask
   // ----
   // Main sequence
   // ----
   initial
   begin
      cyc(10);
      presetn <= 1'b1;
      for (int k = 0; k < 15; k++)
         rd(8'(4 * k), 32'h0);
      rd(8'h3c, 32'h0);
      `CHK("slverr", 1'b1, rerr)
      $display("test reset done");
      // Readback one register at a time, so both pulls are never on together
      for (int k = 0; k < 13; k++)
      begin
         msk = (ra[k] == A_ANALOG) ? 32'hf0 : (ra[k] >= A_DRIVE) ? 32'hffffff : 32'hff;
         wr(ra[k], 32'hffffffff);
         rd(ra[k], msk);
         wr(ra[k], 32'h0);
      end
      rd(A_IRQFLAG, 32'hff);
      wr(A_IRQFLAG, 32'hff);
      rd(A_IRQFLAG, 32'h0);
      wr(A_DIN, 32'hff);
      rd(A_DIN, 32'h0);
      $display("test registers done");
      wr(A_DOUT, 32'h5a);
      wr(A_OUTEN, 32'hff);
      cyc(2);
      `CHK("pin_oe", 8'hff, pin_oe)
      rd(A_DIN, 32'h5a);
      wr(A_ODRAIN, 32'hff);
      cyc(2);
      `CHK("pin_oe", 8'ha5, pin_oe)
      `CHK("pin_o", 8'h00, pin_o)
      wr(A_ODRAIN, 32'h0);
      wr(A_OUTEN, 32'h0);
      ext_en <= 8'h00;
      wr(A_PULLUP, 32'h0f);
      wr(A_PULLDN, 32'hf0);
      cyc(2);
      `CHK("pin_pd_en", 8'hf0, pd)
      `CHK("pin_pu_en", 8'h0f, pu)
      rd(A_DIN, 32'h0f);
      wr(A_PULLUP, 32'h0);
      wr(A_PULLDN, 32'h0);
      ext_en <= 8'hff;
      $display("test pads done");
      wr(A_DRIVE, 32'hfac688);
      cyc(1);
      `CHK("pin_drive", 24'hfac688, drive)
      wr(A_DOUT, 32'h5a);
      wr(A_OUTEN, 32'hff);
      for (int f = 0; f < 8; f++)
      begin
         wr(A_FUNC, {8'h0, {8{f[2:0]}}});
         cyc(8);
         exp64 = '0;
         for (int i = 0; i < 8; i++)
         begin
            // Function 0 shows the written DOUT pattern, others the peripheral bit
            exp8[i] = (f == 0) ? 1'((8'h5a >> i) & 8'h1) : periph_o[i*8+f];
            exp64[i*8+f] = exp8[i];
         end
         `CHK("pin_o", exp8, pin_o)
         `CHK("periph_i", exp64, periph_i)
      end
      wr(A_ANALOG, 32'hff);
      cyc(3);
      `CHK("pin_analog_en", 8'hf0, ana)
      `CHK("periph_i", 32'h0, periph_i[63:32])
      wr(A_ANALOG, 32'h0);
      wr(A_FUNC, 32'h0);
      wr(A_OUTEN, 32'h0);
      $display("test mux done");
      for (int k = 0; k < 9; k++)
         irq_case(cases[k]);
      irq_case(6'b110011);
      `CHK("irq", 1'b0, irq)
      wr(A_IRQEN, 32'h1);
      cyc(2);
      `CHK("irq", 1'b1, irq)
      `CHK("wake", 1'b1, wake)
      wr(A_IRQFLAG, 32'h1);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      $display("test interrupts done");
      ext_val[0] <= 1'b0;
      cyc(8);
      wr(A_IRQFLAG, 32'hff);
      pulse(2);
      rd(A_IRQFLAG, 32'h1);
      wr(A_DEBEN, 32'h1);
      wr(A_IRQFLAG, 32'hff);
      pulse(2);
      rd(A_IRQFLAG, 32'h0);
      ext_val[0] <= 1'b1;
      cyc(12);
      rd(A_DIN, 32'h1);
      // The filtered rise has set the flag; masking must drop irq but keep the flag
      `CHK("irq", 1'b1, irq)
      wr(A_IRQEN, 32'h0);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      `CHK("wake", 1'b0, wake)
      rd(A_IRQFLAG, 32'h1);
      $display("test filter done");
      give_verdict();
   end
endmodule
`default_nettype wire
